// ### rtl/abm_bus_master.sv
// Bus master state sequencer for read and write transfer cycles.
// Assumes bus pins synchronous to CLK; bus clock is CLK divided by two,
// so each bus state S0..S5 lasts one CLK cycle.
`timescale 1ns/10ps
module abm_bus_master
  import abm_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic               CLK,
  input  wire logic               SRST,
  // Request stream
  input  wire logic               REQ_VALID,
  output logic                    REQ_READY,
  input  wire logic [ADDR_W-1:0]  REQ_ADDR,
  input  wire logic [DATA_W-1:0]  REQ_WDATA,
  input  wire logic [SPACE_W-1:0] REQ_SPACE,
  input  wire logic [SIZE_W-1:0]  REQ_SIZE,
  input  wire logic               REQ_RNW,
  input  wire logic               REQ_FAST,
  // Response
  output logic                    RSP_VALID,
  output logic [DATA_W-1:0]       RSP_RDATA,
  output logic [1:0]              RSP_PORT,
  output logic                    RSP_ERROR,
  // Bus outputs
  output logic                    BUS_CLK,
  output logic [ADDR_W-1:0]       ADDR,
  output logic [SPACE_W-1:0]      ADDRESS_SPACE_CODE,
  output logic                    TRANSFER_SIZE_HI,
  output logic                    TRANSFER_SIZE_LO,
  output logic                    READ_NOT_WRITE,
  output logic                    ADDRESS_STROBE_N,
  output logic                    DATA_STROBE_N,
  output logic                    OUTPUT_ENABLE_N,
  output logic [LANES-1:0]        BYTE_WRITE_ENABLES_N,
  // Data bus, split three ways
  input  wire logic [DATA_W-1:0]  DATA_IN,
  output logic [DATA_W-1:0]       DATA_OUT,
  output logic                    DATA_OE,
  // Slave answers
  input  wire logic               TRANSFER_ACK_UPPER_N,
  input  wire logic               TRANSFER_ACK_LOWER_N,
  input  wire logic               BUS_ERROR_N,
  input  wire logic               HALT_N
);
  // ==========================================================
  // Declarations
  abm_fifo_if #(.W(REQ_W)) req_q ();

  abm_state_t         state_r;
  abm_state_t         state_nxt;
  logic [REQ_W-1:0]   cur_r;
  logic [REQ_W-1:0]   nreq;
  logic [REQ_W-1:0]   req_word;
  logic               bus_clk_r, retry_r, err_r, rsp_valid_r;
  logic [DATA_W-1:0]  rdata_r;
  abm_port_t          port_r;
  logic [ADDR_W-1:0]  addr_r;
  logic [SPACE_W-1:0] space_r;
  logic [SIZE_W-1:0]  size_r;
  logic               rnw_r;
  logic [DATA_W-1:0]  wdata_r;
  logic               as_n_r, ds_n_r, oe_n_r;
  logic [LANES-1:0]   we_n_r;
  logic               data_oe_r;
  logic [7:0]         hcnt_r;
  logic [LANES-1:0]   lanes;
  logic               pop, sample, ack_any, bus_error_n, act_nxt, ds_win;
  logic               cur_fast, cur_rnw, n_fast, n_rnw;
  abm_port_t          ack_port;

  // ==========================================================
  // Request queue
  assign req_word = {REQ_FAST, REQ_RNW, REQ_SIZE, REQ_SPACE, REQ_WDATA, REQ_ADDR};

  abm_fifo #(
    .W     (REQ_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .CLK      (CLK),
    .SRST     (SRST),
    .in_valid (REQ_VALID),
    .in_ready (REQ_READY),
    .in_data  (req_word),
    .out      (req_q)
  );

  // Accept a new request only at a rising bus clock edge
  assign req_q.ready = !retry_r && !bus_clk_r && (state_r == ST_IDLE || state_r == ST_S5);
  assign pop         = req_q.valid && req_q.ready;
  assign nreq        = pop ? req_q.data : cur_r;

  // Request fields
  assign cur_fast = cur_r[REQ_FAST_BIT];
  assign cur_rnw  = cur_r[REQ_RNW_BIT];
  assign n_fast   = nreq[REQ_FAST_BIT];
  assign n_rnw    = nreq[REQ_RNW_BIT];

  // Lane selects for the write enables
  abm_lane_dec #(
    .LN (LANES)
  ) u_lanes (
    .size  (nreq[REQ_SIZE_LSB +: SIZE_W]),
    .offs  (nreq[REQ_ADDR_LSB +: 2]),
    .lanes (lanes)
  );

  // ==========================================================
  // Answer sampling
  // Sample at the falling bus edge ending S2 or a wait state
  assign sample  = (state_r == ST_S2 || state_r == ST_W2) && !cur_fast;
  assign ack_any = !TRANSFER_ACK_UPPER_N || !TRANSFER_ACK_LOWER_N;
  assign bus_error_n    = !BUS_ERROR_N;

  // Port size from the acknowledge pair
  always_comb begin
    if (!TRANSFER_ACK_UPPER_N && !TRANSFER_ACK_LOWER_N) begin
      ack_port = PORT_32;
    end else if (!TRANSFER_ACK_UPPER_N) begin
      ack_port = PORT_16;
    end else if (!TRANSFER_ACK_LOWER_N) begin
      ack_port = PORT_8;
    end else begin
      ack_port = PORT_NONE;
    end
  end

  // ==========================================================
  // Sequencer
  // Next bus state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if ((retry_r && HALT_N && !bus_clk_r) || pop) begin
          state_nxt = ST_S0;
        end
      end
      ST_S0: begin
        state_nxt = ST_S1;
      end
      ST_S1: begin
        // Fast cycles skip the answer wait entirely
        state_nxt = cur_fast ? ST_S4 : ST_S2;
      end
      ST_S2, ST_W2: begin
        if (bus_error_n) begin
          state_nxt = ST_S5;
        end else if (ack_any) begin
          state_nxt = ST_S3;
        end else begin
          state_nxt = ST_W1;
        end
      end
      ST_W1: begin
        state_nxt = ST_W2;
      end
      ST_S3: begin
        state_nxt = ST_S4;
      end
      ST_S4: begin
        state_nxt = ST_S5;
      end
      ST_S5: begin
        state_nxt = pop ? ST_S0 : ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // State and bus clock
  always_ff @(posedge CLK) begin
    if (SRST) begin
      state_r   <= ST_IDLE;
      bus_clk_r <= BUS_CLK_RST;
    end else begin
      state_r   <= state_nxt;
      bus_clk_r <= !bus_clk_r;
    end
  end

  // Current request, held over retries
  always_ff @(posedge CLK) begin
    if (SRST) begin
      cur_r <= '0;
    end else if (pop) begin
      cur_r <= req_q.data;
    end
  end

  // Retry and error flags
  always_ff @(posedge CLK) begin
    if (SRST) begin
      retry_r <= 1'b0;
      err_r   <= 1'b0;
    end else begin
      if (sample && bus_error_n) begin
        retry_r <= !HALT_N;
        err_r   <= HALT_N;
      end else if (state_r == ST_IDLE && state_nxt == ST_S0) begin
        retry_r <= 1'b0;
      end else if (state_r == ST_S4) begin
        // Error holds until the next cycle leaves S4
        err_r   <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Address phase
  // Attributes change only when a cycle starts, so they stay valid through S5
  always_ff @(posedge CLK) begin
    if (SRST) begin
      addr_r  <= '0;
      space_r <= '0;
      size_r  <= SIZE_LONG;
      rnw_r   <= 1'b1;
      wdata_r <= '0;
    end else if (pop) begin
      addr_r  <= req_q.data[REQ_ADDR_LSB +: ADDR_W];
      space_r <= req_q.data[REQ_SPACE_LSB +: SPACE_W];
      size_r  <= req_q.data[REQ_SIZE_LSB +: SIZE_W];
      rnw_r   <= req_q.data[REQ_RNW_BIT];
      wdata_r <= req_q.data[REQ_DATA_LSB +: DATA_W];
    end
  end

  // ==========================================================
  // Strobes
  // Strobe windows for the coming state
  assign act_nxt = (state_nxt inside {ST_S1, ST_S2, ST_W1, ST_W2, ST_S3, ST_S4});
  assign ds_win  = n_rnw ? act_nxt : (state_nxt inside {ST_W1, ST_W2, ST_S3, ST_S4});

  // Registered strobes, all negated in S0 and S5
  always_ff @(posedge CLK) begin
    if (SRST) begin
      as_n_r    <= STROBE_RST;
      ds_n_r    <= STROBE_RST;
      oe_n_r    <= STROBE_RST;
      we_n_r    <= WE_RST;
      data_oe_r <= 1'b0;
    end else begin
      as_n_r    <= !act_nxt;
      ds_n_r    <= !(ds_win && !(n_fast && !n_rnw));
      oe_n_r    <= !(act_nxt && n_rnw);
      we_n_r    <= (act_nxt && !n_rnw) ? ~lanes : WE_RST;
      // Write data from S2 (S1 for fast) through S5
      data_oe_r <= !n_rnw && ((state_nxt inside {ST_S2, ST_W1, ST_W2, ST_S3, ST_S4, ST_S5})
                   || (n_fast && state_nxt == ST_S1));
    end
  end

  // ==========================================================
  // Read capture and response
  // Latch data and port size at the falling edge ending S4
  always_ff @(posedge CLK) begin
    if (SRST) begin
      rdata_r <= '0;
      port_r  <= PORT_NONE;
    end else if (sample && bus_error_n) begin
      port_r  <= PORT_NONE;
    end else if (state_r == ST_S4) begin
      port_r  <= cur_fast ? PORT_32 : ack_port;
      if (cur_rnw) begin
        rdata_r <= DATA_IN;
      end
    end
  end

  // One pulse per finished cycle; retried cycles report nothing
  always_ff @(posedge CLK) begin
    if (SRST) begin
      rsp_valid_r <= 1'b0;
    end else begin
      rsp_valid_r <= (state_r == ST_S5) && !retry_r;
    end
  end

  // Half clocks since S0, read only by the checks
  always_ff @(posedge CLK) begin
    if (SRST) begin
      hcnt_r <= '0;
    end else if (state_nxt == ST_S0) begin
      hcnt_r <= '0;
    end else if (hcnt_r != 8'hff) begin
      hcnt_r <= hcnt_r + 8'h01;
    end
  end

  // ==========================================================
  // Outputs
  assign BUS_CLK              = bus_clk_r;
  assign ADDR                 = addr_r;
  assign ADDRESS_SPACE_CODE   = space_r;
  assign TRANSFER_SIZE_HI     = size_r[1];
  assign TRANSFER_SIZE_LO     = size_r[0];
  assign READ_NOT_WRITE       = rnw_r;
  assign ADDRESS_STROBE_N     = as_n_r;
  assign DATA_STROBE_N        = ds_n_r;
  assign OUTPUT_ENABLE_N      = oe_n_r;
  assign BYTE_WRITE_ENABLES_N = we_n_r;
  assign DATA_OUT             = wdata_r;
  assign DATA_OE              = data_oe_r;
  assign RSP_VALID            = rsp_valid_r;
  assign RSP_RDATA            = rdata_r;
  assign RSP_PORT             = port_r;
  assign RSP_ERROR            = err_r;

  // ==========================================================
  // Checks
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SRST);

  a_fast_two_clk:
    assert property ((state_r == ST_S5 && cur_fast) |-> (hcnt_r == 8'(FAST_HALVES - 1)))
    else $error("fast cycle not two bus clocks");
  a_fast_wr_nods:
    assert property ((state_r != ST_IDLE && cur_fast && !cur_rnw) |-> DATA_STROBE_N)
    else $error("data strobe in fast write");
  a_fast_no_ack:
    assert property ((state_r == ST_S1 && cur_fast) |=> (state_r == ST_S4) ##1 (state_r == ST_S5))
    else $error("fast cycle waited on slave");
  a_s0_attrs:
    assert property ((state_r == ST_S0) |-> (READ_NOT_WRITE == cur_rnw && ADDR == cur_r[ADDR_W-1:0]
                     && ADDRESS_STROBE_N && DATA_STROBE_N))
    else $error("S0 attributes wrong");
  a_rd_s1_strobes:
    assert property ((state_r == ST_S1 && cur_rnw) |-> (!ADDRESS_STROBE_N && !DATA_STROBE_N && !OUTPUT_ENABLE_N))
    else $error("read strobes missing in S1");
  a_ack_to_end:
    assert property ((sample && ack_any && !bus_error_n) |=> (state_r == ST_S3) ##1 (state_r == ST_S4) ##1 (state_r == ST_S5))
    else $error("acknowledged cycle did not end");
  a_noack_wait:
    assert property ((sample && !ack_any && !bus_error_n) |=> (state_r == ST_W1 && !ADDRESS_STROBE_N) ##1 (state_r == ST_W2))
    else $error("wait state not inserted");
  a_rd_capture:
    assert property ((state_r == ST_S4 && cur_rnw) |=> (RSP_RDATA == $past(DATA_IN)))
    else $error("read data not captured at S4");
  a_s5_release:
    assert property ((state_r == ST_S5) |-> (ADDRESS_STROBE_N && DATA_STROBE_N && OUTPUT_ENABLE_N
                     && BYTE_WRITE_ENABLES_N == WE_RST && $stable(ADDR) && $stable(READ_NOT_WRITE)))
    else $error("S5 strobes or attributes wrong");
  a_wr_s1_enables:
    assert property ((state_r == ST_S1 && !cur_rnw) |-> (!ADDRESS_STROBE_N && BYTE_WRITE_ENABLES_N == ~lanes))
    else $error("write enables wrong in S1");
  a_wr_s2_data:
    assert property ((state_r == ST_S2 && !cur_rnw) |-> (DATA_OE && DATA_OUT == cur_r[REQ_DATA_LSB +: DATA_W]))
    else $error("write data not driven in S2");
  a_wr_s3_ds:
    assert property ((state_r == ST_S3 && !cur_rnw) |-> !DATA_STROBE_N ##1 (state_r == ST_S4))
    else $error("write data strobe missing in S3");
  a_wr_s4_still:
    assert property ((state_r == ST_S4 && !cur_rnw && !cur_fast) |-> ($stable(ADDRESS_STROBE_N)
                     && $stable(DATA_STROBE_N) && $stable(BYTE_WRITE_ENABLES_N)))
    else $error("controls changed in write S4");
  a_bus_error_n_retry:
    assert property ((sample && bus_error_n && !HALT_N) |=> (state_r == ST_S5 && retry_r) ##1 (state_r == ST_IDLE))
    else $error("bus error with halt did not retry");
  a_min_three:
    assert property ((state_r == ST_S5 && !cur_fast) |-> (hcnt_r >= 8'(ACK_MIN_HALVES - 1)
                     || RSP_ERROR || retry_r))
    else $error("acknowledged cycle shorter than three clocks");
endmodule

// ### rtl/abm_pkg.sv
// Shared constants, field layout and types for the bus master sequencer.
// Assumes one clock; each bus half clock is one core clock cycle.
// Notes on behaviour
// - Internally ended fast cycles finish the bus transfer in two bus clocks.
// - Fast cycles assert data strobe only on reads, never on writes.
// - Fast cycles use an internal acknowledge and ignore the slave's lines.
// - Long reads request four bytes, words two, bytes one, via size pins.
// - Read S0 drives address, space code, size and direction high.
// - Read S1 asserts address strobe, data strobe and output enable.
// - Acknowledge seen at end of S2: latch data at end of S4, finish.
// - No acknowledge at S2: add wait clocks, resample each falling edge.
// - End of S4 captures read data and port size from acknowledge.
// - Read S5 negates strobes, keeps address, direction, size, space valid.
// - Write S0 drives address, space code, size and direction low.
// - Write S1 asserts address strobe with the byte write enables.
// - Write S2 drives the full data bus and samples acknowledge.
// - Write S3 asserts data strobe; acknowledged write ends one clock later.
// - Write S4 keeps controls still; S5 negates enables and strobes.
// - Bus error aborts a cycle; bus error with halt retries it.
// - Externally ended cycles take at least three clocks, extended whole.
package abm_pkg;
  // ==========================================================
  // Widths
  localparam int ADDR_W  = 32;
  localparam int DATA_W  = 32;
  localparam int SPACE_W = 4;
  localparam int SIZE_W  = 2;
  localparam int LANES   = 4;
  // ==========================================================
  // Request word layout
  localparam int REQ_ADDR_LSB  = 0;
  localparam int REQ_DATA_LSB  = 32;
  localparam int REQ_SPACE_LSB = 64;
  localparam int REQ_SIZE_LSB  = 68;
  localparam int REQ_RNW_BIT   = 70;
  localparam int REQ_FAST_BIT  = 71;
  localparam int REQ_W         = 72;
  localparam int FIFO_DEPTH    = 4;
  // ==========================================================
  // Transfer size codes
  localparam logic [1:0] SIZE_LONG = 2'h0;
  localparam logic [1:0] SIZE_BYTE = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  // ==========================================================
  // Timing counts in bus clocks and core cycles
  localparam int FAST_CLKS      = 2;
  localparam int ACK_MIN_CLKS   = 3;
  localparam int HALF_PER_CLK   = 2;
  localparam int FAST_HALVES    = FAST_CLKS * HALF_PER_CLK;
  localparam int ACK_MIN_HALVES = ACK_MIN_CLKS * HALF_PER_CLK;
  // ==========================================================
  // Reset values
  localparam logic       BUS_CLK_RST = 1'b0;
  localparam logic       STROBE_RST  = 1'b1;
  localparam logic [3:0] WE_RST      = 4'hf;
  // ==========================================================
  // Types
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_S0   = 4'h1,
    ST_S1   = 4'h2,
    ST_S2   = 4'h3,
    ST_W1   = 4'h4,
    ST_W2   = 4'h5,
    ST_S3   = 4'h6,
    ST_S4   = 4'h7,
    ST_S5   = 4'h8
  } abm_state_t;
  typedef enum logic [1:0] {
    PORT_32   = 2'h0,
    PORT_16   = 2'h1,
    PORT_8    = 2'h2,
    PORT_NONE = 2'h3
  } abm_port_t;
endpackage

// ### rtl/abm_fifo_if.sv
// Valid/ready carrier between the request queue and the sequencer.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface abm_fifo_if #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ### rtl/abm_fifo.sv
// Request queue with width and depth parameters.
// Assumes synchronous active-high reset; draining side may stall.
`timescale 1ns/10ps
module abm_fifo
  import abm_pkg::*;
#(
  parameter int W     = REQ_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic         CLK,
  input  wire logic         SRST,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  abm_fifo_if.src           out
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem [DEPTH];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [CW-1:0] cnt_r;
  logic          push;
  logic          pop;

  // Honest full and empty
  assign in_ready  = (cnt_r != CW'(DEPTH));
  assign out.valid = (cnt_r != '0);
  assign out.data  = mem[rd_ptr_r];
  assign push      = in_valid && in_ready;
  assign pop       = out.valid && out.ready;

  // Storage
  always_ff @(posedge CLK) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge CLK) begin
    if (SRST) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r    <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == PW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == PW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule

// ### rtl/abm_lane_dec.sv
// Byte lane decode from transfer size and low address bits.
// Assumes a 32-bit port; lane 3 carries byte offset 0.
`timescale 1ns/10ps
module abm_lane_dec
  import abm_pkg::*;
#(
  parameter int LN = LANES
) (
  // Transfer attributes
  input  wire logic [SIZE_W-1:0] size,
  input  wire logic [1:0]        offs,
  // Active-high lane select
  output logic [LN-1:0]          lanes
);
  logic [2:0] nbytes;

  // Long is four bytes, other codes count themselves
  assign nbytes = (size == SIZE_LONG) ? 3'h4 : {1'b0, size};

  // Mark lanes from the offset upward, clipped at the bus edge
  always_comb begin
    lanes = '0;
    for (int k = 0; k < LN; k++) begin
      if (k >= int'(offs) && k < int'(offs) + int'(nbytes)) begin
        lanes[LN-1-k] = 1'b1;
      end
    end
  end
endmodule

// ### tb/abm_slave_model.sv
// Slave model answering the bus master's read and write cycles.
// Assumes one clock; waits, port size and bus error come from the bench.
`timescale 1ns/10ps
module abm_slave_model
  import abm_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              srst,
  // Master side
  input  wire logic              as_n,
  input  wire logic              oe_n,
  input  wire logic              rnw,
  input  wire logic [LANES-1:0]  we_n,
  input  wire logic [DATA_W-1:0] dout,
  input  wire logic              doe,
  // Bench controls
  input  wire logic [3:0]        waits,
  input  wire logic [1:0]        port,
  input  wire logic              bus_error_n,
  // Answers
  output logic [DATA_W-1:0]      din,
  output logic                   ack_u_n,
  output logic                   ack_l_n,
  output logic                   bus_error_n_n
);
  logic [DATA_W-1:0] mem_r;
  logic [4:0]        cnt_r;
  logic              ack_r;
  // ==========================================================
  // Answer after two cycles per wait, drop as soon as the strobe lifts
  always_ff @(posedge clk) begin
    if (srst || as_n) begin
      cnt_r <= 5'h0;
      ack_r <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 5'h1;
      if (cnt_r >= {waits, 1'b0}) begin
        ack_r <= 1'b1;
      end
    end
  end
  // Store the lanes selected by the write enables
  always_ff @(posedge clk) begin
    if (srst) begin
      mem_r <= 32'h0;
    end else if (!as_n && doe && !rnw) begin
      for (int i = 0; i < LANES; i++) begin
        if (!we_n[i]) begin
          mem_r[i*8 +: 8] <= dout[i*8 +: 8];
        end
      end
    end
  end
  // Port size on the pair; released bus shows the inverse
  assign ack_u_n = !(ack_r && !bus_error_n && port != 2'h2);
  assign ack_l_n = !(ack_r && !bus_error_n && port != 2'h1);
  assign bus_error_n_n  = !(ack_r && bus_error_n);
  assign din     = (!oe_n && rnw) ? mem_r : ~mem_r;
endmodule

// ### tb/abm_bus_master_tb.sv
// Self-checking bench for the bus master sequencer.
// Assumes the slave model on the bus; inputs driven at the falling edge.
`timescale 1ns/10ps
`define CHK(g, e, m) begin n_tests++; if ((g) !== (e)) begin error_cnt++; $display("wrong value at %0t: %s", $time, m); end end
module async_bus_master_read_write_tb_top;
  import abm_pkg::*;
  logic clk = 1'b0, srst = 1'b1, req_valid = 1'b0, req_ready, req_rnw = 1'b1, req_fast = 1'b0;
  logic [31:0] req_addr = 32'h0, req_wdata = 32'h0, din, dout, addr;
  logic [1:0]  req_size = 2'h0, rsp_port, port = 2'h0, sz_s;
  logic [3:0]  waits = 4'h0, we_n, we_acc, space;
  logic rsp_valid, rsp_error, as_n, ds_n, rnw, doe, acku, ackl, bus_error_n_n, bus_error_n = 1'b0, rnw_s;
  logic oe_n, bclk, bclk_s, halt_n = 1'b1;
  logic [31:0] rdata;
  int error_cnt = 0, n_tests = 0, as_cnt, ds_cnt;
  // ==========================================================
  always #2 clk = ~clk;
  abm_bus_master i_abm_bus_master (.CLK(clk), .SRST(srst), .REQ_VALID(req_valid), .REQ_READY(req_ready),
    .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata), .REQ_SPACE(4'h5), .REQ_SIZE(req_size), .REQ_RNW(req_rnw),
    .REQ_FAST(req_fast), .RSP_VALID(rsp_valid), .RSP_RDATA(rdata), .RSP_PORT(rsp_port), .RSP_ERROR(rsp_error),
    .BUS_CLK(bclk), .ADDR(addr), .ADDRESS_SPACE_CODE(space), .TRANSFER_SIZE_HI(sz_s[1]),
    .TRANSFER_SIZE_LO(sz_s[0]), .READ_NOT_WRITE(rnw), .ADDRESS_STROBE_N(as_n), .DATA_STROBE_N(ds_n),
    .OUTPUT_ENABLE_N(oe_n),
    .BYTE_WRITE_ENABLES_N(we_n), .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(doe), .TRANSFER_ACK_UPPER_N(acku),
    .TRANSFER_ACK_LOWER_N(ackl), .BUS_ERROR_N(bus_error_n_n), .HALT_N(halt_n));
  abm_slave_model i_abm_slave_model (.clk(clk), .srst(srst), .as_n(as_n), .oe_n(oe_n), .rnw(rnw), .we_n(we_n),
    .dout(dout),
    .doe(doe), .waits(waits), .port(port), .bus_error_n(bus_error_n), .din(din), .ack_u_n(acku), .ack_l_n(ackl),
    .bus_error_n_n(bus_error_n_n));
  // Strobe lengths and first-strobe attributes of the running cycle
  always @(posedge clk) begin
    if (!as_n && as_cnt == 0) begin
      rnw_s = rnw;
      bclk_s = bclk;
    end
    as_cnt += int'(!as_n);
    ds_cnt += int'(!ds_n);
    if (!as_n) begin
      we_acc &= we_n;
    end
  end
  task automatic run(input logic r, input logic f, input logic [31:0] a, input logic [31:0] w, input logic [1:0] s);
    @(negedge clk);
    as_cnt = 0; ds_cnt = 0; we_acc = 4'hf;
    req_valid = 1'b1; req_rnw = r; req_fast = f; req_addr = a; req_wdata = w; req_size = s;
    @(negedge clk);
    req_valid = 1'b0;
    for (int i = 0; i < 400 && rsp_valid !== 1'b1; i++) @(negedge clk);
    `CHK(rsp_valid, 1'b1, "no response")
  endtask
  task automatic t_write();
    run(1'b0, 1'b0, 32'h100, 32'h11223344, SIZE_LONG);
    `CHK(rnw_s, 1'b0, "direction")
    `CHK(we_acc, 4'h0, "long enables")
    `CHK(as_cnt, 4, "write length")
    `CHK(ds_cnt, 2, "write data strobe")
    port = 2'h2; waits = 4'h1;
    run(1'b0, 1'b0, 32'h101, 32'h00aa0000, SIZE_BYTE);
    `CHK(we_acc, 4'hb, "byte enables")
    `CHK(sz_s, SIZE_BYTE, "byte size")
    `CHK(as_cnt, 6, "one wait")
  endtask
  task automatic t_read();
    port = 2'h1; waits = 4'h2;
    run(1'b1, 1'b0, 32'h100, 32'h0, SIZE_LONG);
    `CHK(rdata, 32'h11aa3344, "read data")
    `CHK(rsp_port, 2'h1, "port size")
    `CHK({rnw_s, bclk_s, sz_s, space}, {1'b1, 1'b0, SIZE_LONG, 4'h5}, "read attributes")
    `CHK(as_cnt, 8, "two waits")
    `CHK(ds_cnt, 8, "read data strobe")
    `CHK(addr, 32'h100, "address held")
  endtask
  task automatic t_fast();
    port = 2'h2; waits = 4'h0;
    run(1'b1, 1'b1, 32'h100, 32'h0, SIZE_WORD);
    `CHK(as_cnt, 2, "fast read length")
    `CHK(ds_cnt, 2, "fast read strobe")
    `CHK({rsp_port, rdata}, {2'h0, 32'h11aa3344}, "fast read")
    run(1'b0, 1'b1, 32'h100, 32'h55667788, SIZE_LONG);
    `CHK({as_cnt, ds_cnt}, {32'd2, 32'd0}, "fast write strobes")
  endtask
  task automatic t_bus_error_n();
    bus_error_n = 1'b1;
    run(1'b1, 1'b0, 32'h200, 32'h0, SIZE_BYTE);
    `CHK(rsp_error, 1'b1, "bus error")
    // Bus error with halt: first attempt retried once halt lifts
    halt_n = 1'b0;
    fork
      run(1'b1, 1'b0, 32'h100, 32'h0, SIZE_LONG);
      begin
        @(posedge as_n);
        @(negedge clk);
        bus_error_n = 1'b0;
        halt_n = 1'b1;
      end
    join
    `CHK({rsp_error, rdata}, {1'b0, 32'h55667788}, "retried read")
    `CHK(as_cnt, 6, "retry length")
  endtask
  task automatic t_fill();
    int acc, got;
    acc = 0; got = 0; waits = 4'h6;
    @(negedge clk);
    req_valid = 1'b1; req_rnw = 1'b1; req_fast = 1'b0;
    for (int i = 0; i < 9 && req_ready === 1'b1; i++) begin
      acc++;
      @(negedge clk);
    end
    `CHK(req_ready, 1'b0, "queue never full")
    req_valid = 1'b0;
    `CHK(acc >= FIFO_DEPTH, 1'b1, "queue depth")
    for (int i = 0; i < 2000 && got < acc; i++) begin
      @(negedge clk);
      got += int'(rsp_valid === 1'b1);
    end
    `CHK(got, acc, "drained count")
  endtask
  task automatic test_done();
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Watchdog well beyond the expected run
  initial begin
    #(20000 * 4);
    error_cnt++;
    test_done();
  end
  initial begin
    repeat (2) @(negedge clk);
    srst = 1'b0;
    t_write();
    t_read();
    t_fast();
    t_bus_error_n();
    t_fill();
    test_done();
  end
endmodule
